//--- verilog/access_checker_consts.svh
/*
  Constants for the range-based access checker: register offsets,
  field positions, segment codes and reset values.
  Assumes inclusion by bare name from the design file.
*/
`ifndef ACCESS_CHECKER_CONSTS_SVH
`define ACCESS_CHECKER_CONSTS_SVH

// ****************************************
// register map (byte addresses)
// ****************************************
`define ADDR_W 12
`define TABLE_LIMIT 12'h200
`define OFS_SYSCON 12'h200
`define OFS_STATUS 12'h204
`define OFS_FAULT_ADDR 12'h208
`define FIELD_LOWER 2'h0
`define FIELD_UPPER 2'h1
`define FIELD_MODE 2'h2

// ****************************************
// field positions
// ****************************************
`define SYSCON_DATA_EN_BIT 0
`define SYSCON_CODE_EN_BIT 1
`define WRITE_ENABLE_BIT 7
`define READ_ENABLE_BIT 6
`define EXECUTE_ENABLE_BIT 7

// ****************************************
// privilege levels and segments
// ****************************************
`define PRIV_USER0 2'h0
`define PRIV_USER1 2'h1
`define PRIV_SUPER 2'h2
`define PERIPH_SEG_A 4'he
`define PERIPH_SEG_B 4'hf
`define LOCAL_SEG_A 4'hc
`define LOCAL_SEG_B 4'hd
`define LOCAL_IMPL_BYTES 28'h0010000

// ****************************************
// reset values and bus answers
// ****************************************
`define SYSCON_RESET 2'h0
`define BOUND_RESET 32'h00000000
`define MODE_RESET 8'h00
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

//--- verilog/access_checker_pkg.sv
/*
  Types shared by the range-based access checker.
  Assumes the constants header is compiled alongside.
*/
`default_nettype none

package access_checker_pkg;

  // kind of access presented by the core
  typedef enum logic [1:0] {
    ACC_READ,
    ACC_WRITE,
    ACC_FETCH,
    ACC_NONE
  } access_kind_e;

  // size of an access
  typedef enum logic [1:0] {
    SIZE_BYTE,
    SIZE_HALF,
    SIZE_WORD,
    SIZE_DWORD
  } access_size_e;

endpackage : access_checker_pkg

`default_nettype wire

//--- verilog/range_access_checker.sv
/*
  Range-based access checker: four protection sets of four data and four
  code range entries, reached over AXI4-Lite, judging each core access.
  Assumes core request signals are on REF_CLK and hold for one cycle.
*/
// Behaviour
// - each access is judged before it is forwarded to the bus
// - verdict uses enable bits, privilege level and selected set
// - privilege 0 user, 1 peripheral user, 2 supervisor
// - loads/stores use data table, fetches use code table only
// - data entries grant read/write, code entries grant execute only
// - data read of program memory needs a covering data entry
// - top nibble e or f uses peripheral rules, not tables
// - peripheral access at privilege 0 is refused
// - privilege 1 or 2 passes peripheral accesses to bus, privilege 3 is refused
// - supervisor line driven while privilege is 2
// - protection off: all non-peripheral accesses permitted
// - protection on: address must lie in some range of table
// - any matching entry granting the access type permits it
// - refused access raises a protection trap
// - permitted access to unimplemented local memory raises bus error
// - misaligned access raises alignment trap, not protection trap
// - only the first byte address is checked
// - fetch faults only when it starts in non-executable range
// - set in use comes from status word set select field
// - entry matches when lower <= address < upper
// - four sets selected by two-bit field
// - entry with enable bits clear grants nothing
`timescale 1ns/1ps
`default_nettype none
`include "access_checker_consts.svh"

module range_access_checker
  import access_checker_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // axi4-lite write address
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // axi4-lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read address
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // axi4-lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // core access request
  input wire logic REQ_VALID,
  input wire logic [1:0] REQ_KIND,
  input wire logic [1:0] REQ_SIZE,
  input wire logic [31:0] REQ_ADDR,
  input wire logic [31:0] REQ_WDATA,
  // core status word fields
  input wire logic [1:0] IO_PRIV,
  input wire logic [1:0] SET_SELECT_FIELD,
  // verdict to core
  output logic RESP_VALID,
  output logic TRAP_PROT,
  output logic TRAP_BUS,
  output logic TRAP_ALIGN,
  // forwarded bus request
  output logic BUS_REQ,
  output logic [1:0] BUS_KIND,
  output logic [1:0] BUS_SIZE,
  output logic [31:0] BUS_ADDR,
  output logic [31:0] BUS_WDATA,
  output logic BUS_SUPERVISOR
);

  // ****************************************
  // range tables, index {set, entry}
  // ****************************************
  logic [31:0] data_lower [16];
  logic [31:0] data_upper [16];
  logic [7:0] data_mode [16];
  logic [31:0] code_lower [16];
  logic [31:0] code_upper [16];
  logic [7:0] code_mode [16];
  logic [1:0] syscon;
  logic [15:0] trap_count;
  logic [2:0] last_trap;
  logic [31:0] fault_addr;

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;

  assign do_write = aw_held && w_held && !S_AXI_BVALID;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
    end
    else
    begin
      S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY <= !w_held && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (aw_addr < `TABLE_LIMIT || aw_addr == `OFS_SYSCON) ?
                       `RESP_OKAY : `RESP_DECERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // ****************************************
  // table and configuration writes
  // ****************************************
  logic [3:0] w_idx;
  logic w_code;
  logic [1:0] w_field;
  logic w_table;

  assign w_idx = {aw_addr[8:7], aw_addr[5:4]};
  assign w_code = aw_addr[6];
  assign w_field = aw_addr[3:2];
  assign w_table = do_write && (aw_addr < `TABLE_LIMIT);

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      for (int i = 0; i < 16; i++)
      begin
        data_lower[i] <= `BOUND_RESET;
        data_upper[i] <= `BOUND_RESET;
        data_mode[i] <= `MODE_RESET;
        code_lower[i] <= `BOUND_RESET;
        code_upper[i] <= `BOUND_RESET;
        code_mode[i] <= `MODE_RESET;
      end
    end
    else if (w_table)
    begin
      unique case ({w_code, w_field})
        {1'b0, `FIELD_LOWER}: data_lower[w_idx] <= merge(data_lower[w_idx], w_data, w_strb);
        {1'b0, `FIELD_UPPER}: data_upper[w_idx] <= merge(data_upper[w_idx], w_data, w_strb);
        {1'b0, `FIELD_MODE}:
          data_mode[w_idx] <= w_strb[0] ? w_data[7:0] : data_mode[w_idx];
        {1'b1, `FIELD_LOWER}: code_lower[w_idx] <= merge(code_lower[w_idx], w_data, w_strb);
        {1'b1, `FIELD_UPPER}: code_upper[w_idx] <= merge(code_upper[w_idx], w_data, w_strb);
        {1'b1, `FIELD_MODE}:
          code_mode[w_idx] <= w_strb[0] ? w_data[7:0] : code_mode[w_idx];
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      syscon <= `SYSCON_RESET;
    end
    else if (do_write && aw_addr == `OFS_SYSCON && w_strb[0])
    begin
      syscon <= w_data[1:0];
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  logic [3:0] r_idx;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  assign r_idx = {S_AXI_ARADDR[8:7], S_AXI_ARADDR[5:4]};

  always_comb
  begin
    next_rdata = 32'h00000000;
    next_rresp = `RESP_OKAY;
    if (S_AXI_ARADDR < `TABLE_LIMIT)
    begin
      unique case ({S_AXI_ARADDR[6], S_AXI_ARADDR[3:2]})
        {1'b0, `FIELD_LOWER}: next_rdata = data_lower[r_idx];
        {1'b0, `FIELD_UPPER}: next_rdata = data_upper[r_idx];
        {1'b0, `FIELD_MODE}: next_rdata = {24'h000000, data_mode[r_idx]};
        {1'b1, `FIELD_LOWER}: next_rdata = code_lower[r_idx];
        {1'b1, `FIELD_UPPER}: next_rdata = code_upper[r_idx];
        {1'b1, `FIELD_MODE}: next_rdata = {24'h000000, code_mode[r_idx]};
        default: next_rdata = 32'h00000000;
      endcase
    end
    else if (S_AXI_ARADDR == `OFS_SYSCON)
    begin
      next_rdata = {30'h00000000, syscon};
    end
    else if (S_AXI_ARADDR == `OFS_STATUS)
    begin
      next_rdata = {trap_count, 13'h0000, last_trap};
    end
    else if (S_AXI_ARADDR == `OFS_FAULT_ADDR)
    begin
      next_rdata = fault_addr;
    end
    else
    begin
      next_rresp = `RESP_DECERR;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= `RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= next_rdata;
        S_AXI_RRESP <= next_rresp;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
      begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ****************************************
  // parallel range compare
  // ****************************************
  logic is_fetch;
  logic [3:0] grant;

  assign is_fetch = (access_kind_e'(REQ_KIND) == ACC_FETCH);

  // all four entries of the set at once
  for (genvar e = 0; e < 4; e++)
  begin : g_entry
    logic [3:0] idx;
    logic d_hit;
    logic c_hit;
    // set chosen by status word field
    assign idx = {SET_SELECT_FIELD, 2'(e)};
    assign d_hit = (data_lower[idx] <= REQ_ADDR) && (REQ_ADDR < data_upper[idx]);
    assign c_hit = (code_lower[idx] <= REQ_ADDR) && (REQ_ADDR < code_upper[idx]);
    // table by access kind, grant by kind bit
    always_comb
    begin
      unique case (access_kind_e'(REQ_KIND))
        ACC_READ: grant[e] = d_hit && data_mode[idx][`READ_ENABLE_BIT];
        ACC_WRITE: grant[e] = d_hit && data_mode[idx][`WRITE_ENABLE_BIT];
        ACC_FETCH: grant[e] = c_hit && code_mode[idx][`EXECUTE_ENABLE_BIT];
        ACC_NONE: grant[e] = 1'b0;
      endcase
    end
  end

  // ****************************************
  // verdict
  // ****************************************
  logic periph;
  logic prot_on;
  logic permit;
  logic misaligned;
  logic local_unimpl;
  logic next_trap_align;
  logic next_trap_prot;
  logic next_trap_bus;
  logic active;

  assign active = REQ_VALID && (access_kind_e'(REQ_KIND) != ACC_NONE);
  // upper two segments take peripheral rules
  assign periph = (REQ_ADDR[31:28] == `PERIPH_SEG_A) || (REQ_ADDR[31:28] == `PERIPH_SEG_B);
  // enable bit of the matching table
  assign prot_on = is_fetch ? syscon[`SYSCON_CODE_EN_BIT] : syscon[`SYSCON_DATA_EN_BIT];
  assign local_unimpl = ((REQ_ADDR[31:28] == `LOCAL_SEG_A) || (REQ_ADDR[31:28] == `LOCAL_SEG_B))
                        && (REQ_ADDR[27:0] >= `LOCAL_IMPL_BYTES);

  always_comb
  begin
    if (periph)
    begin
      permit = (IO_PRIV == `PRIV_USER1) || (IO_PRIV == `PRIV_SUPER);
    end
    // off permits all, on needs a granting entry
    else
    begin
      permit = !prot_on || (|grant);
    end
  end

  always_comb
  begin
    unique case (access_size_e'(REQ_SIZE))
      SIZE_BYTE: misaligned = 1'b0;
      SIZE_HALF: misaligned = REQ_ADDR[0];
      SIZE_WORD: misaligned = is_fetch ? REQ_ADDR[0] : (REQ_ADDR[1:0] != 2'h0);
      SIZE_DWORD: misaligned = REQ_ADDR[0];
    endcase
  end

  // alignment trap takes precedence over protection
  assign next_trap_align = active && misaligned;
  // refused access traps, judged at the start address
  assign next_trap_prot = active && !misaligned && !permit;
  assign next_trap_bus = active && !misaligned && permit && !periph && local_unimpl;

  // ****************************************
  // verdict and bus outputs
  // ****************************************
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      RESP_VALID <= 1'b0;
      TRAP_PROT <= 1'b0;
      TRAP_BUS <= 1'b0;
      TRAP_ALIGN <= 1'b0;
      BUS_REQ <= 1'b0;
      BUS_KIND <= 2'h0;
      BUS_SIZE <= 2'h0;
      BUS_ADDR <= 32'h00000000;
      BUS_WDATA <= 32'h00000000;
    end
    else
    begin
      RESP_VALID <= active;
      TRAP_PROT <= next_trap_prot;
      TRAP_BUS <= next_trap_bus;
      TRAP_ALIGN <= next_trap_align;
      // forward only a judged, untrapped access
      BUS_REQ <= active && !next_trap_align && !next_trap_prot && !next_trap_bus;
      BUS_KIND <= REQ_KIND;
      BUS_SIZE <= REQ_SIZE;
      BUS_ADDR <= REQ_ADDR;
      BUS_WDATA <= (access_kind_e'(REQ_KIND) == ACC_WRITE) ? REQ_WDATA : 32'h00000000;
    end
  end

  // supervisor line follows privilege level 2
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      BUS_SUPERVISOR <= 1'b0;
    end
    else
    begin
      BUS_SUPERVISOR <= (IO_PRIV == `PRIV_SUPER);
    end
  end

  // ****************************************
  // trap status for software
  // ****************************************
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      trap_count <= 16'h0000;
      last_trap <= 3'h0;
      fault_addr <= 32'h00000000;
    end
    else if (next_trap_align || next_trap_prot || next_trap_bus)
    begin
      trap_count <= trap_count + 16'h0001;
      last_trap <= {next_trap_bus, next_trap_prot, next_trap_align};
      fault_addr <= REQ_ADDR;
    end
  end

endmodule : range_access_checker

`default_nettype wire

//--- tb/range_checker_asserts.sv
/*
  Checker of the core verdict port and the forwarded bus request.
  Assumes it is bound onto range_access_checker and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module range_checker_asserts
  import access_checker_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  // core request
  input wire logic REQ_VALID,
  input wire logic [1:0] REQ_KIND,
  input wire logic [1:0] REQ_SIZE,
  input wire logic [31:0] REQ_ADDR,
  input wire logic [1:0] IO_PRIV,
  // verdict and bus
  input wire logic RESP_VALID,
  input wire logic TRAP_PROT,
  input wire logic TRAP_BUS,
  input wire logic TRAP_ALIGN,
  input wire logic BUS_REQ,
  input wire logic [31:0] BUS_ADDR,
  input wire logic BUS_SUPERVISOR
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);

  logic req;
  logic byte_periph;
  logic any_trap;
  assign req = REQ_VALID && REQ_KIND != 2'h3;
  assign byte_periph = req && REQ_SIZE == 2'h0 && REQ_ADDR[31:29] == 3'h7;
  assign any_trap = TRAP_PROT || TRAP_BUS || TRAP_ALIGN;

  // ****************************************
  // verdict timing and form
  // ****************************************
  a_verdict_next: assert property (req |=> RESP_VALID)
    else $error("no verdict one cycle after request");
  a_no_idle_verdict: assert property (!req |=> !RESP_VALID)
    else $error("verdict without request");
  a_single_trap: assert property (RESP_VALID |-> $onehot0({TRAP_PROT, TRAP_BUS, TRAP_ALIGN}))
    else $error("more than one trap");
  a_trap_blocks_bus: assert property (any_trap |-> !BUS_REQ && RESP_VALID)
    else $error("trapped access forwarded");
  a_verdict_given: assert property (RESP_VALID |-> BUS_REQ || any_trap)
    else $error("verdict neither forwarded nor trapped");
  a_half_misalign: assert property (req && REQ_SIZE == 2'h1 && REQ_ADDR[0] |=> TRAP_ALIGN)
    else $error("odd halfword not alignment trap");

  // ****************************************
  // peripheral segments and bus side
  // ****************************************
  a_user0_periph: assert property (byte_periph && IO_PRIV == 2'h0 |=> TRAP_PROT)
    else $error("user-0 peripheral access not refused");
  a_user1_periph: assert property (byte_periph && IO_PRIV inside {2'h1, 2'h2} |=> BUS_REQ)
    else $error("privileged peripheral access not forwarded");
  a_super_line: assert property ($past(RST_B) |-> BUS_SUPERVISOR == ($past(IO_PRIV) == 2'h2))
    else $error("supervisor line wrong");
  a_first_byte: assert property (BUS_REQ |-> BUS_ADDR == $past(REQ_ADDR))
    else $error("forwarded address differs");

  c_prot: cover property (RESP_VALID && TRAP_PROT);
  c_bus_err: cover property (RESP_VALID && TRAP_BUS);
  c_super: cover property (BUS_REQ && BUS_SUPERVISOR);
endmodule : range_checker_asserts

bind range_access_checker range_checker_asserts u_range_checker_asserts (
  .REF_CLK(REF_CLK),
  .RST_B(RST_B),
  .REQ_VALID(REQ_VALID),
  .REQ_KIND(REQ_KIND),
  .REQ_SIZE(REQ_SIZE),
  .REQ_ADDR(REQ_ADDR),
  .IO_PRIV(IO_PRIV),
  .RESP_VALID(RESP_VALID),
  .TRAP_PROT(TRAP_PROT),
  .TRAP_BUS(TRAP_BUS),
  .TRAP_ALIGN(TRAP_ALIGN),
  .BUS_REQ(BUS_REQ),
  .BUS_ADDR(BUS_ADDR),
  .BUS_SUPERVISOR(BUS_SUPERVISOR)
);

`default_nettype wire

//--- tb/core_access_model.sv
/*
  Model of the core load/store and fetch units plus one protected peripheral.
  Assumes the checker answers one cycle after each request.
*/
`timescale 1ns/1ps
`default_nettype none

module core_access_model (
  // clock
  input wire logic ref_clk,
  // request to checker
  output logic req_valid,
  output logic [1:0] req_kind,
  output logic [1:0] req_size,
  output logic [31:0] req_addr,
  output logic [31:0] req_wdata,
  output logic [1:0] io_priv,
  output logic [1:0] set_sel,
  // verdict and bus
  input wire logic resp_valid,
  input wire logic trap_prot,
  input wire logic trap_bus,
  input wire logic trap_align,
  input wire logic bus_req,
  input wire logic [31:0] bus_addr,
  input wire logic bus_supervisor
);
  logic accept;
  assign accept = bus_req && bus_supervisor && bus_addr[31:28] == 4'hf;

  initial
  begin
    req_valid = 1'b0;
    req_kind = 2'h3;
    req_size = 2'h0;
    req_addr = 32'h0;
    req_wdata = 32'h0;
    io_priv = 2'h0;
    set_sel = 2'h0;
  end

  // one request, verdict taken the cycle after
  task automatic issue(input logic [1:0] k, s, input logic [31:0] a,
                       input logic [1:0] p, ss, output logic [5:0] v);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_size <= s;
    req_addr <= a;
    req_wdata <= ~a;
    io_priv <= p;
    set_sel <= ss;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    req_kind <= 2'h3;
    req_addr <= ~a;
    #1;
    v = {accept, resp_valid, bus_req, trap_prot, trap_bus, trap_align};
  endtask : issue
endmodule : core_access_model

`default_nettype wire

//--- tb/tb.sv
/*
  Testbench of the range access checker: registers over AXI4-Lite,
  verdicts through the core model. Assumes a 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("[FAIL] %s exp %h got %h", n, e, g); \
    end \
  end

module tb;
  import access_checker_pkg::*;
  logic ref_clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, req_valid, resp_valid;
  logic trap_prot, trap_bus, trap_align, bus_req, bus_super;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, req_addr, req_wdata, bus_addr, rd;
  logic [1:0] bresp, rresp, req_kind, req_size, io_priv, set_sel, resp;
  logic [5:0] v;
  logic [1:0] bus_kind, bus_size;
  logic [31:0] bus_wdata;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;

  range_access_checker u_range_access_checker (
    .REF_CLK(ref_clk), .RST_B(rst_b),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .REQ_VALID(req_valid),
    .REQ_KIND(req_kind), .REQ_SIZE(req_size), .REQ_ADDR(req_addr),
    .REQ_WDATA(req_wdata), .IO_PRIV(io_priv), .SET_SELECT_FIELD(set_sel),
    .RESP_VALID(resp_valid), .TRAP_PROT(trap_prot), .TRAP_BUS(trap_bus),
    .TRAP_ALIGN(trap_align), .BUS_REQ(bus_req), .BUS_KIND(bus_kind), .BUS_SIZE(bus_size),
    .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata), .BUS_SUPERVISOR(bus_super)
  );

  core_access_model u_core_access_model (
    .ref_clk(ref_clk), .req_valid(req_valid), .req_kind(req_kind),
    .req_size(req_size), .req_addr(req_addr), .req_wdata(req_wdata),
    .io_priv(io_priv), .set_sel(set_sel), .resp_valid(resp_valid),
    .trap_prot(trap_prot), .trap_bus(trap_bus), .trap_align(trap_align),
    .bus_req(bus_req), .bus_addr(bus_addr), .bus_supervisor(bus_super)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ****************************************
  // bus tasks
  // ****************************************
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic ent(input logic [11:0] b, input logic [31:0] lo, up, md);
    axi_wr(b, lo);
    axi_wr(b + 12'h4, up);
    axi_wr(b + 12'h8, md);
  endtask : ent

  task automatic cs(input logic [1:0] k, s, input logic [31:0] a,
                    input logic [1:0] p, ss, input logic [5:0] e);
    u_core_access_model.issue(k, s, a, p, ss, v);
    `CHK("verdict", e, v)
  endtask : cs

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    axi_rd(12'h200);
    `CHK("syscon reset", 32'h0, rd)
    axi_rd(12'h300);
    `CHK("unmapped read", 2'h3, resp)
    axi_wr(12'h204, 32'h1);
    `CHK("status write", 2'h3, resp)
  endtask : t_regs

  task automatic t_off;
    cs(2'h0, 2'h2, 32'h1000, 2'h0, 2'h0, 6'h18);
    cs(2'h3, 2'h2, 32'h1000, 2'h0, 2'h0, 6'h00);
    for (int p = 0; p < 3; p++)
    begin
      cs(2'h1, 2'h0, 32'hf000_0010, p[1:0], 2'h0, p == 0 ? 6'h14 : (p == 1 ? 6'h18 : 6'h38));
      cs(2'h0, 2'h0, 32'he000_0010, p[1:0], 2'h0, p == 0 ? 6'h14 : 6'h18);
    end
    cs(2'h0, 2'h2, 32'hf000_0002, 2'h0, 2'h0, 6'h11);
  endtask : t_off

  task automatic t_tables;
    ent(12'h080, 32'h1000, 32'h2000, 32'h40);
    ent(12'h090, 32'h1800, 32'h1900, 32'h80);
    ent(12'h0a0, 32'h3000, 32'h4000, 32'h0);
    ent(12'h0c0, 32'h8000, 32'h9000, 32'h80);
    ent(12'h1b0, 32'h5000, 32'h5100, 32'h40);
    axi_rd(12'h088);
    `CHK("mode read back", 32'h40, rd)
    axi_wr(12'h200, 32'h3);
    `CHK("syscon write", 2'h0, resp)
    cs(2'h0, 2'h2, 32'h1000, 2'h1, 2'h1, 6'h18);
    `CHK("read wdata", 32'h0, bus_wdata)
    cs(2'h0, 2'h2, 32'h2000, 2'h1, 2'h1, 6'h14);
    cs(2'h1, 2'h2, 32'h1000, 2'h1, 2'h1, 6'h14);
    cs(2'h1, 2'h2, 32'h1800, 2'h1, 2'h1, 6'h18);
    `CHK("bus kind", 2'h1, bus_kind)
    `CHK("bus size", 2'h2, bus_size)
    `CHK("bus wdata", 32'hffff_e7ff, bus_wdata)
    cs(2'h0, 2'h2, 32'h3000, 2'h1, 2'h1, 6'h14);
    cs(2'h2, 2'h2, 32'h1000, 2'h1, 2'h1, 6'h14);
    cs(2'h2, 2'h1, 32'h8ffe, 2'h1, 2'h1, 6'h18);
    cs(2'h2, 2'h2, 32'h9000, 2'h1, 2'h1, 6'h14);
    cs(2'h0, 2'h2, 32'h8000, 2'h1, 2'h1, 6'h14);
    cs(2'h0, 2'h2, 32'h1000, 2'h1, 2'h0, 6'h14);
    cs(2'h0, 2'h2, 32'h5000, 2'h1, 2'h3, 6'h18);
    cs(2'h0, 2'h3, 32'h1ffe, 2'h1, 2'h1, 6'h18);
    cs(2'h0, 2'h1, 32'h1001, 2'h1, 2'h1, 6'h11);
    cs(2'h0, 2'h2, 32'he000_0000, 2'h1, 2'h1, 6'h18);
    axi_wr(12'h200, 32'h1);
    cs(2'h2, 2'h2, 32'h1000, 2'h1, 2'h1, 6'h18);
    cs(2'h0, 2'h2, 32'h2000, 2'h1, 2'h1, 6'h14);
  endtask : t_tables

  task automatic t_bus_err;
    axi_wr(12'h200, 32'h0);
    cs(2'h0, 2'h2, 32'hd000_fffc, 2'h0, 2'h0, 6'h18);
    cs(2'h0, 2'h0, 32'hc001_0000, 2'h0, 2'h0, 6'h12);
    axi_rd(12'h208);
    `CHK("fault address", 32'hc001_0000, rd)
    axi_rd(12'h204);
    `CHK("last trap kind", 3'h4, rd[2:0])
    `CHK("trap count", 16'h000d, rd[31:16])
    cs(2'h0, 2'h0, 32'he000_0000, 2'h3, 2'h0, 6'h14);
  endtask : t_bus_err

  task automatic finish_test;
    $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      finish_test();
    end
  end

  initial
  begin
    rst_b = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 12'h0;
    araddr = 12'h0;
    wdata = 32'h0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs();
    t_off();
    t_tables();
    t_bus_err();
    finish_test();
  end
endmodule : tb

`default_nettype wire
